//--- mssir_host.sv
// Host processor model issuing single AHB-Lite word or byte transfers.
// Assumes the one slave's hreadyout is looped back as hready.
`timescale 1ns/1ps
module mssir_host (
  input  wire logic        clk_sys,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel = 1'b0,
  output logic [31:0]      haddr = '0,
  output logic [1:0]       htrans = 2'b00,
  output logic             hwrite = 1'b0,
  output logic [2:0]       hsize = 3'd2,
  output logic [31:0]      hwdata = '0
);
  // Commands and acknowledging reads all go through here
  task automatic xfer(input logic [31:0] a, input logic [2:0] sz, input logic w,
                      input logic [31:0] wd, output logic [31:0] rdat, output bit to);
    int n;
    to = 0;
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      if (hready) break;
    end
    to = !hready;
    htrans <= 2'b00;
    if (w) hwdata <= wd;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      if (hready) break;
    end
    to = to || !hready;
    rdat = hrdata;
  endtask
endmodule

//--- mssir_pkg.sv
// Package for the motion status and interrupt factor register bank.
// Assumes a 32-bit AHB-Lite slave port and one 25 MHz system clock.
package mssir_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MSSIR_OFS_MAIN   = 8'h00;
  localparam logic [7:0] MSSIR_OFS_IFACT  = 8'h04;
  localparam logic [7:0] MSSIR_OFS_ERR    = 8'h08;
  localparam logic [7:0] MSSIR_OFS_IEN    = 8'h0c;
  localparam logic [7:0] MSSIR_OFS_CMD    = 8'h10;

  localparam logic [15:0] MSSIR_RST_IEN   = 16'h0000;
  localparam logic [15:0] MSSIR_RST_IFACT = 16'h0000;
  localparam logic [6:0]  MSSIR_RST_ERR   = 7'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MSSIR_B_CEND  = 6;
  localparam int MSSIR_B_DEND  = 7;
  localparam int MSSIR_B_HEND  = 8;
  localparam int MSSIR_B_TIMER = 9;
  localparam int MSSIR_B_SPLIT_EACH_PULSE_IRQ = 10;
  localparam int MSSIR_B_SPLIT_DONE_IRQ = 11;
  localparam int MSSIR_B_SYNC  = 12;

  // ----------------------------------------------------------------
  // Host commands
  // ----------------------------------------------------------------
  localparam logic [7:0] MSSIR_CMD_ERR_CLEAR = 8'h79;
  localparam logic [7:0] MSSIR_CMD_SYNC_EN   = 8'h80;
  localparam logic [7:0] MSSIR_CMD_SYNC_DIS  = 8'h90;

  // Drive and home state, speed and jerk phase, timer and split status reported by the motion generator
  typedef struct packed {
    logic driving;
    logic home_busy;
    logic accel_phase;
    logic constant_speed_phase;
    logic decel_phase;
    logic jerk_rising_phase;
    logic jerk_flat_phase;
    logic jerk_falling_phase;
    logic timer_run;
    logic split_run;
  } mssir_motion_type;

  // One-cycle event pulses from the motion generator
  typedef struct packed {
    logic       drive_start;
    logic       const_end;
    logic       drive_end;
    logic       home_end;
    logic       timer_expire;
    logic       split_pulse;
    logic       split_end;
    logic [3:0] sync_fire;
  } mssir_event_type;

endpackage

//--- mssir_regs.sv
// Main motion status, error detail and interrupt factor registers.
// Assumes event pulses are one cycle wide and synchronous to clk_sys.
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module mssir_regs #(
  parameter int SYNC_COUNT = 4
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire mssir_pkg::mssir_motion_type motion,
  input  wire mssir_pkg::mssir_event_type  events,
  input  wire logic [6:0]                 err_cause,
  input  wire logic                       servo_in_position_wait_en,
  input  wire logic                       servo_in_position,
  output logic [3:0]                      sync_action_flags,
  output logic                            err_clear_cmd,
  output logic                            irq_out_n
);
  import mssir_pkg::*;

  // The status and factor layouts have room for exactly four synchronous actions
  if (SYNC_COUNT != 4) begin : g_bad_sync_count
    $error("SYNC_COUNT must be 4");
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  logic       ap_valid;
  logic       ap_write;
  logic [7:0] ap_addr;
  logic [2:0] ap_size;
  logic [1:0] ap_lane;

  wire        take   = hsel && hready && htrans[1];
  wire        wr_dp  = ap_valid && ap_write;
  wire [7:0]  wr_cmd = hwdata[7:0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
      ap_size  <= 3'd0;
      ap_lane  <= 2'd0;
    end else begin
      ap_valid <= take && hwrite;
      ap_write <= hwrite;
      ap_addr  <= {haddr[7:2], 2'b00};
      ap_size  <= hsize;
      ap_lane  <= haddr[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire        wr_ien     = wr_dp && (ap_addr == MSSIR_OFS_IEN);
  wire        wr_cmdreg  = wr_dp && (ap_addr == MSSIR_OFS_CMD);
  wire        cmd_clear  = wr_cmdreg && (wr_cmd == MSSIR_CMD_ERR_CLEAR);
  wire        cmd_sen    = wr_cmdreg && (wr_cmd[7:4] == MSSIR_CMD_SYNC_EN[7:4])
                           && (wr_cmd[3:0] != 4'h0);
  wire        cmd_sdis   = wr_cmdreg && (wr_cmd[7:4] == MSSIR_CMD_SYNC_DIS[7:4])
                           && (wr_cmd[3:0] != 4'h0);

  logic [15:0] interrupt_enable_reg;
  logic [15:0] interrupt_factor_status;
  logic [6:0]  error_finish_status;
  logic        hold_drive;
  logic        driving_q;

  // Command low nibble selects which synchronous actions change
  wire [3:0] next_sync = cmd_sen  ? (sync_action_flags |  wr_cmd[3:0]) :
                         cmd_sdis ? (sync_action_flags & ~wr_cmd[3:0]) :
                                    sync_action_flags;

  // Detail bits latch; drive start or clear command wipes them
  wire       err_wipe  = cmd_clear || events.drive_start;
  wire [6:0] next_err  = err_wipe ? err_cause
                                  : (error_finish_status | err_cause);

  // ----------------------------------------------------------------
  // Interrupt factors
  // ----------------------------------------------------------------
  wire [15:0] raw_evt;
  assign raw_evt[5:0]                          = 6'h00;
  assign raw_evt[MSSIR_B_CEND]                 = events.const_end;
  assign raw_evt[MSSIR_B_DEND]                 = events.drive_end;
  assign raw_evt[MSSIR_B_HEND]                 = events.home_end;
  assign raw_evt[MSSIR_B_TIMER]                = events.timer_expire;
  assign raw_evt[MSSIR_B_SPLIT_EACH_PULSE_IRQ]                = events.split_pulse;
  assign raw_evt[MSSIR_B_SPLIT_DONE_IRQ]                = events.split_end;
  assign raw_evt[MSSIR_B_SYNC+3:MSSIR_B_SYNC]  = events.sync_fire;

  wire [15:0] set_evt = raw_evt & interrupt_enable_reg;

  // Read of the factor word clears only the bytes actually read
  wire        rd_take  = take && !hwrite && ({haddr[7:2], 2'b00} == MSSIR_OFS_IFACT);
  wire        rd_word  = hsize[1];
  wire        clr_lo   = rd_take && (rd_word || (hsize == 3'd1 && !haddr[1])
                                     || (hsize == 3'd0 && haddr[1:0] == 2'd0));
  wire        clr_hi   = rd_take && (rd_word || (hsize == 3'd1 && !haddr[1])
                                     || (hsize == 3'd0 && haddr[1:0] == 2'd1));
  wire [15:0] clr_mask = {{8{clr_hi}}, {8{clr_lo}}};
  wire [15:0] next_ifact = (interrupt_factor_status & ~clr_mask) | set_evt;

  // ----------------------------------------------------------------
  // Drive status with optional in-position wait
  // ----------------------------------------------------------------
  wire drive_fall = driving_q && !motion.driving;
  wire next_hold  = servo_in_position_wait_en && !servo_in_position
                    && (drive_fall || hold_drive) && !motion.driving;

  wire [15:0] main_motion_status = {
    2'b00,
    motion.split_run,
    motion.timer_run,
    sync_action_flags,
    motion.jerk_falling_phase,
    motion.jerk_flat_phase,
    motion.jerk_rising_phase,
    motion.decel_phase,
    motion.constant_speed_phase,
    motion.accel_phase,
    |error_finish_status,
    // next_hold covers the cycle in which driving falls, so bit 0 never gaps
    motion.driving || motion.home_busy || hold_drive || next_hold
  };

  wire [15:0] rd_sel =
    (haddr[7:2] == MSSIR_OFS_MAIN[7:2])  ? main_motion_status :
    (haddr[7:2] == MSSIR_OFS_IFACT[7:2]) ? interrupt_factor_status :
    (haddr[7:2] == MSSIR_OFS_ERR[7:2])   ? {9'h000, error_finish_status} :
    (haddr[7:2] == MSSIR_OFS_IEN[7:2])   ? interrupt_enable_reg : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interrupt_enable_reg    <= MSSIR_RST_IEN;
      interrupt_factor_status <= MSSIR_RST_IFACT;
      error_finish_status     <= MSSIR_RST_ERR;
      sync_action_flags       <= 4'h0;
      hold_drive              <= 1'b0;
      driving_q               <= 1'b0;
      err_clear_cmd           <= 1'b0;
      irq_out_n               <= 1'b1;
      hrdata                  <= 32'h0000_0000;
    end else begin
      if (wr_ien) begin
        interrupt_enable_reg <= hwdata[15:0];
      end
      interrupt_factor_status <= next_ifact;
      error_finish_status     <= next_err;
      sync_action_flags       <= next_sync;
      hold_drive              <= next_hold;
      driving_q               <= motion.driving;
      err_clear_cmd           <= cmd_clear;
      irq_out_n               <= ~(|next_ifact);
      if (take && !hwrite) begin
        hrdata <= {16'h0000, rd_sel};
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

//--- mssir_regs_monitor.sv
// Port checker for the status and interrupt factor bank.
// Assumes the bind below attaches it to every bank instance.
`timescale 1ns/1ps
module mssir_regs_monitor
  import mssir_pkg::*;
#(parameter int SYNC_COUNT = 4) (
  input wire logic                        clk_sys,
  input wire logic                        rst,
  input wire logic                        hsel,
  input wire logic [31:0]                 haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic [2:0]                  hsize,
  input wire logic [31:0]                 hwdata,
  input wire logic                        hready,
  input wire logic [31:0]                 hrdata,
  input wire mssir_pkg::mssir_motion_type motion,
  input wire mssir_pkg::mssir_event_type  events,
  input wire logic [3:0]                  sync_action_flags,
  input wire logic                        err_clear_cmd,
  input wire logic                        irq_out_n
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire rd_t = hsel && hready && htrans[1] && !hwrite;
  wire wr_t = hsel && hready && htrans[1] && hwrite;
  wire rd0  = rd_t && haddr[7:0] == 8'h00;
  logic [9:0] m_q;
  always_ff @(posedge clk_sys) m_q <= motion;
  property p_speed; rd0 |=> hrdata[4:2] == {m_q[5], m_q[6], m_q[7]}; endproperty
  a_speed: assert property (p_speed) else $error("speed phase bits wrong");
  property p_jerk; rd0 |=> hrdata[7:5] == {m_q[2], m_q[3], m_q[4]}; endproperty
  a_jerk: assert property (p_jerk) else $error("jerk phase bits wrong");
  property p_timer; rd0 |=> hrdata[12] == m_q[1]; endproperty
  a_timer: assert property (p_timer) else $error("timer bit wrong");
  property p_split; rd0 |=> hrdata[13] == m_q[0]; endproperty
  a_split: assert property (p_split) else $error("split bit wrong");
  property p_irq_hold; !irq_out_n && !rd_t |=> !irq_out_n; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped unread");
  property p_irq_clear;
    rd_t && haddr[7:0] == 8'h04 && hsize == 3'd2 && events == '0 |=> irq_out_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq kept after read");
  property p_flags; $changed(sync_action_flags) |-> $past(wr_t, 2) || $past(wr_t, 3); endproperty
  a_flags: assert property (p_flags) else $error("sync flags moved alone");
  property p_clr;
    err_clear_cmd |-> $past(hwdata[7:0]) == 8'h79 || $past(hwdata[7:0], 2) == 8'h79;
  endproperty
  a_clr: assert property (p_clr) else $error("error clear without command");
  c_irq: cover property (!irq_out_n);
  c_rd0: cover property (rd0);
  c_clr: cover property (err_clear_cmd);
endmodule
bind mssir_regs mssir_regs_monitor #(.SYNC_COUNT(SYNC_COUNT)) mon_u (.clk_sys(clk_sys),
  .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .motion(motion), .events(events),
  .sync_action_flags(sync_action_flags), .err_clear_cmd(err_clear_cmd),
  .irq_out_n(irq_out_n));

//--- tb_motion_status_interrupt_regs.sv
// Self-checking bench for the status and interrupt factor bank.
// Assumes the host model drives the bus and the bench drives motion events.
`timescale 1ns/1ps
module tb_motion_status_interrupt_regs;
  import mssir_pkg::*;
  logic clk_sys = 0, rst = 1, hsel, hwrite, hrdy, irq_out_n, servo_in_position_wait_en = 0, servo_in_pos = 0;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] err_cause = '0;
  logic [3:0] sync_action_flags;
  mssir_motion_type motion = '0;
  mssir_event_type events = '0;
  int err_count = 0, comparisons = 0, f;
  localparam int MAP [10] = '{13, 12, 7, 6, 5, 4, 3, 2, 0, 0};
  always #20 clk_sys = ~clk_sys;
  mssir_host host_u (.clk_sys(clk_sys), .hready(hrdy), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  mssir_regs dut_u (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(), .motion(motion), .events(events),
    .err_cause(err_cause), .servo_in_position_wait_en(servo_in_position_wait_en), .servo_in_position(servo_in_pos),
    .sync_action_flags(sync_action_flags), .err_clear_cmd(), .irq_out_n(irq_out_n));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic [2:0] sz, input logic w,
                     input logic [31:0] wd);
    bit to;
    host_u.xfer({24'h0, a}, sz, w, wd, rdv, to);
    if (to) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    acc(a, 3'd2, 1'b0, '0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(a, 3'd2, 1'b1, d);
  endtask
  // Events last exactly one cycle, as the motion generator makes them
  task automatic pulse(input logic [10:0] e);
    @(posedge clk_sys);
    events <= e;
    @(posedge clk_sys);
    events <= '0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (MAP[i]) begin
      rd(8'h04 * (i % 5));
      check("idle reg", rdv, 0);
      motion <= mssir_motion_type'(10'd1 << i);
      rd(8'h00);
      check("status phase", rdv, 32'd1 << MAP[i]);
      motion <= '0;
    end
    servo_in_position_wait_en <= 1'b1;
    motion <= mssir_motion_type'(10'h200);
    rd(8'h00);
    motion <= '0;
    rd(8'h00);
    check("drive hold", rdv, 1);
    servo_in_pos <= 1'b1;
    rd(8'h00);
    check("drive released", rdv, 0);
    $display("test status done");
    wr(8'h0c, 32'h0000_ffc0);
    for (int j = 0; j < 10; j++) begin
      f = (j < 4) ? 12 + j : 15 - j;
      pulse(11'd1 << j);
      check("irq asserted", irq_out_n, 0);
      rd(8'h04);
      check("factor", rdv, 32'd1 << f);
      check("irq released", irq_out_n, 1);
    end
    wr(8'h0c, 32'h0000_ff40);
    pulse(11'h100);
    check("masked irq", irq_out_n, 1);
    pulse(11'h240);
    acc(8'h05, 3'd0, 1'b0, '0);
    rd(8'h04);
    check("low lane kept", rdv, 32'h0000_0040);
    $display("test interrupt done");
    err_cause <= 7'h04;
    @(posedge clk_sys);
    err_cause <= '0;
    rd(8'h00);
    check("error sum", rdv, 2);
    rd(8'h08);
    check("error latched", rdv, 4);
    wr(8'h10, 32'h0000_0079);
    rd(8'h00);
    check("error cleared", rdv, 0);
    err_cause <= 7'h40;
    @(posedge clk_sys);
    err_cause <= '0;
    pulse(11'h400);
    rd(8'h08);
    check("drive start clear", rdv, 0);
    wr(8'h10, 32'h0000_008f);
    wr(8'h10, 32'h0000_0092);
    rd(8'h00);
    check("sync status", rdv, 32'h0000_0d00);
    check("sync flags", sync_action_flags, 4'hd);
    $display("test error and sync done");
    complete_run();
  end
endmodule
